// file: ppbc_top.sv
`timescale 1ns/1ns
`default_nettype none
module ppbc_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // register port, dword index
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [ppbc_pkg::IDX_W-1:0] reg_idx_i,
  input wire logic [ppbc_pkg::DW-1:0] reg_wdata_i,
  output logic [ppbc_pkg::DW-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // clock-role pins, oe low while driving
  input wire logic [ppbc_pkg::NUM_PAIRS-1:0] pclk_in_i,
  output logic [ppbc_pkg::NUM_PAIRS-1:0] pclk_out_o,
  output logic [ppbc_pkg::NUM_PAIRS-1:0] pclk_oe_n_o,
  // data-role pins, oe low while driving
  input wire logic [ppbc_pkg::NUM_PAIRS-1:0] pdat_in_i,
  output logic [ppbc_pkg::NUM_PAIRS-1:0] pdat_out_o,
  output logic [ppbc_pkg::NUM_PAIRS-1:0] pdat_oe_n_o
);
  localparam int unsigned NP = ppbc_pkg::NUM_PAIRS;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  // async assert, two flop release
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  ppbc_sync_if sif ();

  assign sif.clk_raw = pclk_in_i;
  assign sif.dat_raw = pdat_in_i;

  ppbc_sync i_ppbc_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_sync_r),
    .sif(sif.sync)
  );

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  logic [NP-1:0] wr_hit;
  logic [NP-1:0] clk_val_r;
  logic [NP-1:0] clk_dir_r;
  logic [NP-1:0] dat_val_r;
  logic [NP-1:0] dat_dir_r;
  logic [NP-1:0] clk_val_nxt;
  logic [NP-1:0] clk_dir_nxt;
  logic [NP-1:0] dat_val_nxt;
  logic [NP-1:0] dat_dir_nxt;

  // decode an access to one pair register; slots past the last pair hit nothing
  function automatic logic pair_hit(input logic [ppbc_pkg::IDX_W-1:0] idx,
                                    input int unsigned pair);
    pair_hit = (idx == pair[ppbc_pkg::IDX_W-1:0]) &&
               (idx <= ppbc_pkg::PAIR_CTL_LAST_IDX);
  endfunction

  // masked update of a stored bit: the strobe picks new over old
  function automatic logic masked(input logic hit, input logic mask_b,
                                  input logic new_b, input logic old_b);
    masked = (hit && mask_b) ? new_b : old_b;
  endfunction

  // one-hot select of the pair register taking this write
  always_comb begin
    wr_hit = '0;
    for (int p = 0; p < NP; p++) begin
      wr_hit[p] = reg_wr_i && pair_hit(reg_idx_i, p);
    end
  end

  // ------------------------------------------------------------
  // masked next values
  // ------------------------------------------------------------
  // clock-role bits, each guarded by its own strobe in the same word
  always_comb begin
    clk_val_nxt = clk_val_r;
    clk_dir_nxt = clk_dir_r;
    for (int p = 0; p < NP; p++) begin
      clk_val_nxt[p] = masked(wr_hit[p], reg_wdata_i[ppbc_pkg::CLK_VAL_MASK_BIT],
                              reg_wdata_i[ppbc_pkg::CLK_VAL_BIT], clk_val_r[p]);
      clk_dir_nxt[p] = masked(wr_hit[p], reg_wdata_i[ppbc_pkg::CLK_DIR_MASK_BIT],
                              reg_wdata_i[ppbc_pkg::CLK_DIR_BIT], clk_dir_r[p]);
    end
  end

  // data-role bits, strobes themselves are never kept
  always_comb begin
    dat_val_nxt = dat_val_r;
    dat_dir_nxt = dat_dir_r;
    for (int p = 0; p < NP; p++) begin
      dat_val_nxt[p] = masked(wr_hit[p], reg_wdata_i[ppbc_pkg::DAT_VAL_MASK_BIT],
                              reg_wdata_i[ppbc_pkg::DAT_VAL_BIT], dat_val_r[p]);
      dat_dir_nxt[p] = masked(wr_hit[p], reg_wdata_i[ppbc_pkg::DAT_DIR_MASK_BIT],
                              reg_wdata_i[ppbc_pkg::DAT_DIR_BIT], dat_dir_r[p]);
    end
  end

  // ------------------------------------------------------------
  // stored control bits
  // ------------------------------------------------------------
  // clock-role output value, idles high like the bus pull-up
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      clk_val_r <= {NP{ppbc_pkg::CLK_VAL_RST}};
    end else begin
      clk_val_r <= clk_val_nxt;
    end
  end

  // clock-role direction, input after reset
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      clk_dir_r <= {NP{ppbc_pkg::CLK_DIR_RST}};
    end else begin
      clk_dir_r <= clk_dir_nxt;
    end
  end

  // data-role output value, idles high like the bus pull-up
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      dat_val_r <= {NP{ppbc_pkg::DAT_VAL_RST}};
    end else begin
      dat_val_r <= dat_val_nxt;
    end
  end

  // data-role direction, input after reset
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      dat_dir_r <= {NP{ppbc_pkg::DAT_DIR_RST}};
    end else begin
      dat_dir_r <= dat_dir_nxt;
    end
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // clock-role pad, released whenever the direction bit says input
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pclk_out_o <= {NP{ppbc_pkg::CLK_VAL_RST}};
      pclk_oe_n_o <= ~{NP{ppbc_pkg::CLK_DIR_RST}};
    end else begin
      pclk_out_o <= clk_val_r;
      pclk_oe_n_o <= ~clk_dir_r;
    end
  end

  // data-role pad, released whenever the direction bit says input
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pdat_out_o <= {NP{ppbc_pkg::DAT_VAL_RST}};
      pdat_oe_n_o <= ~{NP{ppbc_pkg::DAT_DIR_RST}};
    end else begin
      pdat_out_o <= dat_val_r;
      pdat_oe_n_o <= ~dat_dir_r;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [ppbc_pkg::DW-1:0] rd_nxt;

  // assemble word; masks and reserved bits stay zero
  always_comb begin
    rd_nxt = ppbc_pkg::RDATA_RST;
    for (int p = 0; p < NP; p++) begin
      if (pair_hit(reg_idx_i, p)) begin
        rd_nxt[ppbc_pkg::CLK_DIR_BIT] = clk_dir_r[p];
        rd_nxt[ppbc_pkg::CLK_VAL_BIT] = clk_val_r[p];
        rd_nxt[ppbc_pkg::CLK_IN_BIT] = sif.clk_sync[p];
        rd_nxt[ppbc_pkg::DAT_DIR_BIT] = dat_dir_r[p];
        rd_nxt[ppbc_pkg::DAT_VAL_BIT] = dat_val_r[p];
        rd_nxt[ppbc_pkg::DAT_IN_BIT] = sif.dat_sync[p];
      end
    end
  end

  // registered read answer, one cycle after request
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata_o <= ppbc_pkg::RDATA_RST;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      reg_rdata_o <= reg_rd_i ? rd_nxt : ppbc_pkg::RDATA_RST;
    end
  end
endmodule
`default_nettype wire

// file: ppbc_pkg.sv
package ppbc_pkg;
  // ------------------------------------------------------------
  // register array geometry
  // ------------------------------------------------------------
  localparam int unsigned NUM_PAIRS = 6;
  localparam int unsigned DW = 32;
  localparam int unsigned IDX_W = 3;
  // dword index of each pair register, byte address is four times it
  localparam logic [IDX_W-1:0] PAIR_CTL_0_IDX = 3'h0;
  localparam logic [IDX_W-1:0] PAIR_CTL_LAST_IDX = 3'h5;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned CLK_DIR_MASK_BIT = 0;
  localparam int unsigned CLK_DIR_BIT = 1;
  localparam int unsigned CLK_VAL_MASK_BIT = 2;
  localparam int unsigned CLK_VAL_BIT = 3;
  localparam int unsigned CLK_IN_BIT = 4;
  localparam int unsigned DAT_DIR_MASK_BIT = 8;
  localparam int unsigned DAT_DIR_BIT = 9;
  localparam int unsigned DAT_VAL_MASK_BIT = 10;
  localparam int unsigned DAT_VAL_BIT = 11;
  localparam int unsigned DAT_IN_BIT = 12;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic CLK_VAL_RST = 1'h1;
  localparam logic CLK_DIR_RST = 1'h0;
  localparam logic DAT_VAL_RST = 1'h1;
  localparam logic DAT_DIR_RST = 1'h0;
  localparam logic [DW-1:0] RDATA_RST = 32'h0000_0000;
endpackage

// file: ppbc_sync_if.sv
`timescale 1ns/1ns
`default_nettype none
// raw pin levels in, synchronised levels out
interface ppbc_sync_if;
  logic [ppbc_pkg::NUM_PAIRS-1:0] clk_raw;
  logic [ppbc_pkg::NUM_PAIRS-1:0] dat_raw;
  logic [ppbc_pkg::NUM_PAIRS-1:0] clk_sync;
  logic [ppbc_pkg::NUM_PAIRS-1:0] dat_sync;
  modport core (output clk_raw, output dat_raw, input clk_sync, input dat_sync);
  modport sync (input clk_raw, input dat_raw, output clk_sync, output dat_sync);
endinterface
`default_nettype wire

// file: ppbc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ppbc_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pin levels
  ppbc_sync_if.sync sif
);
  logic [2*ppbc_pkg::NUM_PAIRS-1:0] meta_r;
  logic [2*ppbc_pkg::NUM_PAIRS-1:0] sync_r;

  // two stage synchroniser, first stage read only by second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {sif.dat_raw, sif.clk_raw};
      sync_r <= meta_r;
    end
  end

  assign sif.clk_sync = sync_r[ppbc_pkg::NUM_PAIRS-1:0];
  assign sif.dat_sync = sync_r[2*ppbc_pkg::NUM_PAIRS-1:ppbc_pkg::NUM_PAIRS];
endmodule
`default_nettype wire

// file: ppbc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module ppbc_pin_model (
  // pad side of the block
  input wire logic [5:0] pclk_out_i,
  input wire logic [5:0] pclk_oe_n_i,
  input wire logic [5:0] pdat_out_i,
  input wire logic [5:0] pdat_oe_n_i,
  // a far device stretching the clock line
  input wire logic [5:0] pull_clk_i,
  // resolved line levels
  output logic [5:0] clk_lvl_o,
  output logic [5:0] dat_lvl_o
);
  // pulled-up lines: released reads high, a low puller wins
  assign clk_lvl_o = (pclk_oe_n_i | pclk_out_i) & ~pull_clk_i;
  assign dat_lvl_o = pdat_oe_n_i | pdat_out_i;
endmodule
`default_nettype wire

// file: ppbc_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ppbc_checker (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [2:0] reg_idx_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [5:0] pclk_in_i,
  input wire logic [5:0] pclk_out_o,
  input wire logic [5:0] pclk_oe_n_o,
  input wire logic [5:0] pdat_in_i,
  input wire logic [5:0] pdat_out_o,
  input wire logic [5:0] pdat_oe_n_o
);
  logic [11:0] pin_d1, pin_d2, pin_d3;
  logic [2:0] up_cnt;
  logic quiet;
  // pin history, so input reads are judged only on settled levels
  always_ff @(posedge sys_clk_i) begin
    pin_d1 <= {pclk_in_i, pdat_in_i};
    pin_d2 <= pin_d1;
    pin_d3 <= pin_d2;
  end
  // cycles since reset, saturating
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h7) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  assign quiet = (up_cnt == 3'h7) && (pin_d1 == {pclk_in_i, pdat_in_i}) &&
    (pin_d2 == pin_d1) && (pin_d3 == pin_d2);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  mask_zero_a: assert property (reg_rvalid_o |-> (reg_rdata_o & 32'hffff_e5e5) == 32'h0)
    else $error("mask or reserved bit read nonzero");
  clk_dir_a: assert property (reg_wr_i && reg_idx_i < 3'h6 && reg_wdata_i[0] |->
    ##2 pclk_oe_n_o[$past(reg_idx_i, 2)] == !$past(reg_wdata_i[1], 2)) else $error("clock dir");
  clk_val_a: assert property (reg_wr_i && reg_idx_i < 3'h6 && reg_wdata_i[2] |->
    ##2 pclk_out_o[$past(reg_idx_i, 2)] == $past(reg_wdata_i[3], 2)) else $error("clock value");
  dat_dir_a: assert property (reg_wr_i && reg_idx_i < 3'h6 && reg_wdata_i[8] |->
    ##2 pdat_oe_n_o[$past(reg_idx_i, 2)] == !$past(reg_wdata_i[9], 2)) else $error("data dir");
  dat_val_a: assert property (reg_wr_i && reg_idx_i < 3'h6 && reg_wdata_i[10] |->
    ##2 pdat_out_o[$past(reg_idx_i, 2)] == $past(reg_wdata_i[11], 2)) else $error("data value");
  pins_hold_a: assert property (!reg_wr_i || reg_idx_i > 3'h5 ||
    (reg_wdata_i & 32'h0000_0505) == 32'h0 |=> ##1
    $stable({pclk_out_o, pclk_oe_n_o, pdat_out_o, pdat_oe_n_o})) else $error("pins moved");
  input_sync_a: assert property (reg_rd_i && reg_idx_i < 3'h6 && quiet |=>
    {reg_rdata_o[12], reg_rdata_o[4]} ==
    {$past(pdat_in_i[reg_idx_i]), $past(pclk_in_i[reg_idx_i])}) else $error("input bits");
  unmapped_read_a: assert property (reg_rd_i && reg_idx_i > 3'h5 |=> reg_rdata_o == 32'h0)
    else $error("unmapped read nonzero");
endmodule
bind ppbc_top ppbc_checker i_ppbc_checker (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .pclk_in_i(pclk_in_i),
  .pclk_out_o(pclk_out_o), .pclk_oe_n_o(pclk_oe_n_o), .pdat_in_i(pdat_in_i),
  .pdat_out_o(pdat_out_o), .pdat_oe_n_o(pdat_oe_n_o));
`default_nettype wire

// file: tb_pin_pair_bitbang_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_pin_pair_bitbang_control;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [2:0] reg_idx_i = 3'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic reg_rvalid_o;
  logic [5:0] pci, pco, pcoe, pdi, pdo, pdoe;
  logic [5:0] pull_clk = 6'h0;
  int fail_count = 0;
  int check_count = 0;
  // core clock, 8 ns period
  always #4 sys_clk_i = ~sys_clk_i;
  ppbc_top i_ppbc_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_idx_i(reg_idx_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .pclk_in_i(pci),
    .pclk_out_o(pco), .pclk_oe_n_o(pcoe), .pdat_in_i(pdi), .pdat_out_o(pdo),
    .pdat_oe_n_o(pdoe));
  ppbc_pin_model i_ppbc_pin_model (.pclk_out_i(pco), .pclk_oe_n_i(pcoe), .pdat_out_i(pdo),
    .pdat_oe_n_i(pdoe), .pull_clk_i(pull_clk), .clk_lvl_o(pci), .dat_lvl_o(pdi));
  // verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one register write, then time for pins and synchronisers to settle
  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_idx_i <= idx;
    reg_wdata_i <= d & 32'h0000_1f1f;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  // one register read, answer judged in the cycle it stands
  task automatic rd(input logic [2:0] idx, input logic [31:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_idx_i <= idx;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check_count++;
    if (reg_rvalid_o !== 1'b1 || reg_rdata_o !== exp) begin
      fail_count++;
      $display("[FAIL] rdata idx %0d expected %h seen %h", idx, exp, reg_rdata_o);
    end
  endtask
  // pad drivers of one pair: clock value, clock oe_n, data value, data oe_n
  task automatic pins(input int p, input logic [3:0] exp);
    check_count++;
    if ({pco[p], pcoe[p], pdo[p], pdoe[p]} !== exp) begin
      fail_count++;
      $display("[FAIL] pins pair %0d expected %b seen %b", p, exp,
               {pco[p], pcoe[p], pdo[p], pdoe[p]});
    end
  endtask
  // reset, then every register at its reset value with lines released
  task automatic t_reset;
    rst_n_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    for (int p = 0; p < 6; p++) begin
      rd(3'(p), 32'h0000_1818);
      pins(p, 4'hf);
    end
    $display("reset test done");
  endtask
  // masked updates, directions and sampled levels on each pair
  // every far device counts as present, so all six pairs are used
  task automatic t_pairs;
    for (int p = 0; p < 6; p++) begin
      wr(3'(p), 32'h0000_0307);
      rd(3'(p), 32'h0000_1a02);
      pins(p, 4'h2);
      wr(3'(p), 32'h0000_1a1a);
      rd(3'(p), 32'h0000_1a02);
      if (p < 5) rd(3'(p + 1), 32'h0000_1818);
      wr(3'(p), 32'h0000_0405);
      rd(3'(p), 32'h0000_0210);
      pins(p, 4'h4);
      @(posedge sys_clk_i);
      pull_clk[p] <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rd(3'(p), 32'h0000_0200);
      @(posedge sys_clk_i);
      pull_clk[p] <= 1'b0;
      wr(3'(p), 32'h0000_0100);
      rd(3'(p), 32'h0000_1010);
      pins(p, 4'h5);
    end
    $display("pair test done");
  endtask
  // unmapped slots take nothing and read zero
  task automatic t_unmapped;
    wr(3'h6, 32'h0000_0f0f);
    rd(3'h6, 32'h0);
    rd(3'h7, 32'h0);
    for (int p = 0; p < 6; p++) rd(3'(p), 32'h0000_1010);
    $display("unmapped test done");
  endtask
  // main sequence, second reset after the last test
  initial begin
    t_reset;
    t_pairs;
    t_unmapped;
    @(posedge sys_clk_i);
    t_reset;
    end_of_test;
  end
  // watchdog, well beyond the expected few thousand ns
  initial begin
    #20000;
    fail_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
